// file: include/low_power_pkg.sv
package low_power_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int           ADDR_W           = 8;
    localparam int           DATA_W           = 32;
    localparam logic [7:0]   OFS_CTRL         = 8'h00;
    localparam logic [7:0]   OFS_STATUS       = 8'h04;
    localparam logic [7:0]   OFS_ACK          = 8'h08;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int           CTRL_STOP_EN     = 0;
    localparam int           CTRL_LVD_EN      = 1;
    localparam int           CTRL_LVD_STOP    = 2;
    localparam int           CTRL_PPD         = 3;
    localparam int           CTRL_IREF_EN     = 4;
    localparam int           CTRL_IREF_STOP   = 5;
    localparam int           CTRL_EREF_EN     = 6;
    localparam int           CTRL_EREF_STOP   = 7;
    localparam int           CTRL_EREF_HIGH   = 8;
    localparam int           CTRL_W           = 9;
    localparam logic [8:0]   CTRL_RESET       = 9'h000;

    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int           STAT_STATE_LO    = 0;
    localparam int           STAT_SEL_LO      = 2;
    localparam int           STAT_PPD_FLAG    = 5;
    localparam int           STAT_PIN_LATCH   = 6;
    localparam int           STAT_DBG_LATCH   = 7;
    localparam int           ACK_BIT          = 0;

    // ------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        sel_illegal,
        sel_stop3_debug,
        sel_stop3_reg,
        sel_stop3,
        sel_stop2
    } stop_sel_e;

    typedef enum logic [1:0] {
        st_run,
        st_wait,
        st_stop3,
        st_stop2
    } pm_state_e;

endpackage

// file: design/stop_mode_select.sv
`timescale 1ns/1ps
module stop_mode_select (
    input  wire logic                   stop_instr_enable,
    input  wire logic                   debug_mode_enable,
    input  wire logic                   low_volt_detect_enable,
    input  wire logic                   low_volt_stop_enable,
    input  wire logic                   partial_powerdown_ctrl,
    output low_power_pkg::stop_sel_e    sel
);

    always_comb begin
        if (!stop_instr_enable) begin
            sel = low_power_pkg::sel_illegal;
        end else if (debug_mode_enable) begin
            sel = low_power_pkg::sel_stop3_debug;
        end else if (low_volt_detect_enable && low_volt_stop_enable) begin
            sel = low_power_pkg::sel_stop3_reg;
        end else if (partial_powerdown_ctrl) begin
            sel = low_power_pkg::sel_stop2;
        end else begin
            sel = low_power_pkg::sel_stop3;
        end
    end

endmodule

// file: design/debug_cmd_filter.sv
`timescale 1ns/1ps
module debug_cmd_filter (
    input  wire logic   low_power,
    input  wire logic   debug_alive,
    input  wire logic   cmd_valid,
    input  wire logic   cmd_background,
    input  wire logic   cmd_mem_status,
    output logic        accept,
    output logic        status_error,
    output logic        background_enter
);

    // With its clock stopped the debug logic hears nothing at all
    always_comb begin
        accept           = 1'b0;
        status_error     = 1'b0;
        background_enter = 1'b0;
        if (cmd_valid) begin
            if (!low_power) begin
                accept           = 1'b1;
                background_enter = cmd_background;
            end else if (debug_alive) begin
                accept           = cmd_background || cmd_mem_status;
                status_error     = cmd_mem_status && !cmd_background;
                background_enter = cmd_background;
            end
        end
    end

endmodule

// file: design/low_power_mode_control.sv
// Notes on behaviour
// - Wait instruction stops CPU clock and clears the interrupt mask bit.
// - Any interrupt ends wait; CPU resumes with interrupt stacking.
// - Asleep, debug accepts only background and status memory commands; latter report error.
// - Background command during wait wakes into active background mode.
// - Stop with stop enable clear gives illegal opcode reset, no low power.
// - Stop enable and debug enable set: stop3 with debug kept running.
// - Debug off, both low-voltage bits set: stop3 with regulator active.
// - Otherwise powerdown control 0 picks stop3, 1 picks stop2.
// - Any stop halts bus, CPU and peripheral clocks, even with debug running.
// - Stop3 keeps registers, logic, RAM and pin states.
// - Stop3 ends on reset pin or listed peripheral and pin interrupts.
// - Reset pin exit resets chip; interrupt exit takes that interrupt vector.
// - Debug enabled at stop keeps debug clock and full regulation.
// - With debug enabled, background command wakes stop into active background.
// - Stop2 powers down all but RAM and latches pin controls.
// - Stop2 ends only on reset pin or enabled real-time counter wake.
// - Stop2 wake restarts as power-on: registers reset, reset vector fetched.
// - Stop2 wake sets powerdown flag; flag and pin latch clear on ack write.
// - Peripherals re-enabled before ack; afterwards pins follow port controls.
// - Stop3 reference clocks run only with enable and stop-enable bits set.
`timescale 1ns/1ps
module low_power_mode_control (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           clk_en,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [7:0]     paddr,
    input  wire logic [31:0]    pwdata,
    output logic [31:0]         prdata,
    output logic                pready,
    output logic                pslverr,
    input  wire logic           wait_exec,
    input  wire logic           stop_exec,
    input  wire logic           reset_pin_n,
    input  wire logic           rtc_wake_enable,
    input  wire logic           irq_rtc,
    input  wire logic           irq_lvd,
    input  wire logic           irq_analog_comparator,
    input  wire logic           irq_adc,
    input  wire logic           irq_sci,
    input  wire logic           irq_pin,
    input  wire logic           irq_other,
    input  wire logic           debug_mode_enable,
    input  wire logic           dbg_cmd_valid,
    input  wire logic           dbg_cmd_background,
    input  wire logic           dbg_cmd_mem_status,
    output logic                cpu_clk_en,
    output logic                bus_clk_en,
    output logic                periph_clk_en,
    output logic                debug_clk_en,
    output logic                regulator_full,
    output logic                int_ref_run,
    output logic                ext_ref_run,
    output logic                state_retain,
    output logic                core_powerdown,
    output logic                pin_latch,
    output logic                int_mask_clear,
    output logic                irq_resume,
    output logic                chip_reset,
    output logic                por_restart,
    output logic                illegal_opcode_reset,
    output logic                dbg_accept,
    output logic                dbg_status_error,
    output logic                active_bg_enter
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [8:0]                 ctrl;
    low_power_pkg::pm_state_e   state;
    low_power_pkg::pm_state_e   next_state;
    low_power_pkg::stop_sel_e   sel_now;
    low_power_pkg::stop_sel_e   sel_held;
    logic                       partial_powerdown_flag;
    logic                       bus_setup;
    logic                       bus_done;
    logic                       wr_ctrl;
    logic                       wr_ack;
    logic                       ack_write;
    logic                       stop3_wake_irq;
    logic                       stop2_wake;
    logic                       low_power;
    logic                       debug_alive;
    logic                       flt_accept;
    logic                       flt_error;
    logic                       flt_bg;
    logic                       lvd_in_stop;
    logic [31:0]                status_word;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    // ------------------------------------------------------------
    // APB slave: no wait states, pready and data from flops
    // ------------------------------------------------------------
    assign bus_setup = psel && !penable && !pready;
    assign bus_done  = psel && penable && pready;
    assign wr_ctrl   = bus_done && pwrite && hit(paddr, low_power_pkg::OFS_CTRL);
    assign wr_ack    = bus_done && pwrite && hit(paddr, low_power_pkg::OFS_ACK);
    assign ack_write = wr_ack && pwdata[low_power_pkg::ACK_BIT];

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[low_power_pkg::STAT_STATE_LO +: 2] = state;
        status_word[low_power_pkg::STAT_SEL_LO +: 3]   = sel_held;
        status_word[low_power_pkg::STAT_PPD_FLAG]      = partial_powerdown_flag;
        status_word[low_power_pkg::STAT_PIN_LATCH]     = pin_latch;
        status_word[low_power_pkg::STAT_DBG_LATCH]     = debug_alive;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (clk_en) begin
            if (bus_done) begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end else if (bus_setup) begin
                pready  <= 1'b1;
                prdata  <= 32'h0000_0000;
                pslverr <= 1'b0;
                if (hit(paddr, low_power_pkg::OFS_CTRL)) begin
                    prdata[low_power_pkg::CTRL_W-1:0] <= ctrl;
                end else if (hit(paddr, low_power_pkg::OFS_STATUS)) begin
                    prdata <= status_word;
                end else if (!hit(paddr, low_power_pkg::OFS_ACK)) begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Control register; a stop2 restart returns it to reset
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= low_power_pkg::CTRL_RESET;
        end else if (clk_en) begin
            if (state == low_power_pkg::st_stop2 && stop2_wake) begin
                ctrl <= low_power_pkg::CTRL_RESET;
            end else if (wr_ctrl) begin
                ctrl <= pwdata[low_power_pkg::CTRL_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------
    stop_mode_select u_sel (
        .stop_instr_enable      (ctrl[low_power_pkg::CTRL_STOP_EN]),
        .debug_mode_enable      (debug_mode_enable),
        .low_volt_detect_enable (ctrl[low_power_pkg::CTRL_LVD_EN]),
        .low_volt_stop_enable   (ctrl[low_power_pkg::CTRL_LVD_STOP]),
        .partial_powerdown_ctrl (ctrl[low_power_pkg::CTRL_PPD]),
        .sel                    (sel_now)
    );

    // Held for the whole stop so mid-stop writes cannot shift the mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_held    <= low_power_pkg::sel_stop3;
            lvd_in_stop <= 1'b0;
        end else if (clk_en && state == low_power_pkg::st_run && stop_exec) begin
            sel_held    <= sel_now;
            lvd_in_stop <= ctrl[low_power_pkg::CTRL_LVD_EN] && ctrl[low_power_pkg::CTRL_LVD_STOP];
        end
    end

    // ------------------------------------------------------------
    // Wake sources
    // ------------------------------------------------------------
    assign stop3_wake_irq = irq_rtc || irq_lvd || irq_analog_comparator || irq_adc || irq_sci || irq_pin;
    assign stop2_wake     = !reset_pin_n || (irq_rtc && rtc_wake_enable);
    assign low_power      = state != low_power_pkg::st_run;
    assign debug_alive    = state == low_power_pkg::st_wait
                            || (state == low_power_pkg::st_stop3 && sel_held == low_power_pkg::sel_stop3_debug);

    debug_cmd_filter u_dbg (
        .low_power        (low_power),
        .debug_alive      (debug_alive),
        .cmd_valid        (dbg_cmd_valid),
        .cmd_background   (dbg_cmd_background),
        .cmd_mem_status   (dbg_cmd_mem_status),
        .accept           (flt_accept),
        .status_error     (flt_error),
        .background_enter (flt_bg)
    );

    // ------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            low_power_pkg::st_run: begin
                if (wait_exec) begin
                    next_state = low_power_pkg::st_wait;
                end else if (stop_exec && sel_now == low_power_pkg::sel_stop2) begin
                    next_state = low_power_pkg::st_stop2;
                end else if (stop_exec && sel_now != low_power_pkg::sel_illegal) begin
                    next_state = low_power_pkg::st_stop3;
                end
            end
            low_power_pkg::st_wait: begin
                if (irq_other || stop3_wake_irq || flt_bg) begin
                    next_state = low_power_pkg::st_run;
                end
            end
            low_power_pkg::st_stop3: begin
                if (!reset_pin_n || stop3_wake_irq || flt_bg) begin
                    next_state = low_power_pkg::st_run;
                end
            end
            low_power_pkg::st_stop2: begin
                if (stop2_wake) begin
                    next_state = low_power_pkg::st_run;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= low_power_pkg::st_run;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Clock and power controls, registered from the next state
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_clk_en     <= 1'b1;
            bus_clk_en     <= 1'b1;
            periph_clk_en  <= 1'b1;
            debug_clk_en   <= 1'b1;
            regulator_full <= 1'b1;
            state_retain   <= 1'b0;
            core_powerdown <= 1'b0;
        end else if (clk_en) begin
            cpu_clk_en     <= next_state == low_power_pkg::st_run;
            bus_clk_en     <= next_state == low_power_pkg::st_run
                              || next_state == low_power_pkg::st_wait;
            periph_clk_en  <= next_state == low_power_pkg::st_run
                              || next_state == low_power_pkg::st_wait;
            state_retain   <= next_state == low_power_pkg::st_stop3;
            core_powerdown <= next_state == low_power_pkg::st_stop2;
            unique case (next_state)
                low_power_pkg::st_stop3: begin
                    debug_clk_en   <= (state == low_power_pkg::st_run ? sel_now : sel_held)
                                      == low_power_pkg::sel_stop3_debug;
                    regulator_full <= (state == low_power_pkg::st_run ? sel_now : sel_held)
                                      inside {low_power_pkg::sel_stop3_debug, low_power_pkg::sel_stop3_reg};
                end
                low_power_pkg::st_stop2: begin
                    debug_clk_en   <= 1'b0;
                    regulator_full <= 1'b0;
                end
                low_power_pkg::st_run, low_power_pkg::st_wait: begin
                    debug_clk_en   <= 1'b1;
                    regulator_full <= 1'b1;
                end
            endcase
        end
    end

    // Reference clocks; in stop3 the high range oscillator also needs detection kept on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_ref_run <= 1'b0;
            ext_ref_run <= 1'b0;
        end else if (clk_en) begin
            unique case (next_state)
                low_power_pkg::st_stop3: begin
                    int_ref_run <= ctrl[low_power_pkg::CTRL_IREF_EN]
                                   && ctrl[low_power_pkg::CTRL_IREF_STOP];
                    ext_ref_run <= ctrl[low_power_pkg::CTRL_EREF_EN]
                                   && ctrl[low_power_pkg::CTRL_EREF_STOP]
                                   && (!ctrl[low_power_pkg::CTRL_EREF_HIGH]
                                       || (state == low_power_pkg::st_run
                                           ? ctrl[low_power_pkg::CTRL_LVD_EN]
                                             && ctrl[low_power_pkg::CTRL_LVD_STOP]
                                           : lvd_in_stop));
                end
                low_power_pkg::st_stop2: begin
                    int_ref_run <= 1'b0;
                    ext_ref_run <= 1'b0;
                end
                low_power_pkg::st_run, low_power_pkg::st_wait: begin
                    int_ref_run <= ctrl[low_power_pkg::CTRL_IREF_EN];
                    ext_ref_run <= ctrl[low_power_pkg::CTRL_EREF_EN];
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Stop2 pin latch and recovery flag; in the ack cycle a wake wins for the flag, stop2 entry for the latch
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_latch              <= 1'b0;
            partial_powerdown_flag <= 1'b0;
        end else if (clk_en) begin
            if (next_state == low_power_pkg::st_stop2) begin
                pin_latch <= 1'b1;
            end else if (ack_write) begin
                pin_latch <= 1'b0;
            end
            if (state == low_power_pkg::st_stop2 && stop2_wake) begin
                partial_powerdown_flag <= 1'b1;
            end else if (ack_write) begin
                partial_powerdown_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // One-cycle event pulses to the CPU and reset logic
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask_clear       <= 1'b0;
            irq_resume           <= 1'b0;
            chip_reset           <= 1'b0;
            por_restart          <= 1'b0;
            illegal_opcode_reset <= 1'b0;
        end else if (clk_en) begin
            int_mask_clear       <= state == low_power_pkg::st_run && wait_exec;
            illegal_opcode_reset <= state == low_power_pkg::st_run && !wait_exec
                                    && stop_exec && sel_now == low_power_pkg::sel_illegal;
            irq_resume           <= (state == low_power_pkg::st_wait && (irq_other || stop3_wake_irq))
                                    || (state == low_power_pkg::st_stop3 && reset_pin_n && stop3_wake_irq);
            chip_reset           <= state == low_power_pkg::st_stop3 && !reset_pin_n;
            por_restart          <= state == low_power_pkg::st_stop2 && stop2_wake;
        end
    end

    // ------------------------------------------------------------
    // Debug command answers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbg_accept       <= 1'b0;
            dbg_status_error <= 1'b0;
            active_bg_enter  <= 1'b0;
        end else if (clk_en) begin
            dbg_accept       <= flt_accept;
            dbg_status_error <= flt_error;
            active_bg_enter  <= flt_bg && !(state == low_power_pkg::st_stop3 && !reset_pin_n);
        end
    end

endmodule

// file: tb/lpm_props.sv
`timescale 1ns/1ps
module lpm_props (
    input wire logic pclk, presetn, clk_en, wait_exec, stop_exec, reset_pin_n, irq_other, irq_rtc,
    input wire logic dbg_cmd_valid, dbg_cmd_mem_status, dbg_cmd_background, dbg_status_error,
    input wire logic cpu_clk_en, bus_clk_en, periph_clk_en, debug_clk_en, regulator_full,
    input wire logic state_retain, core_powerdown, pin_latch, int_mask_clear, irq_resume,
    input wire logic chip_reset, por_restart, illegal_opcode_reset
);
    // ----
    // Power sequencing checks
    // ----
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_stop2_wake;
        clk_en && core_powerdown && !reset_pin_n;
    endsequence
    sequence s_restart;
        por_restart && pin_latch && cpu_clk_en ##1 !por_restart;
    endsequence
    a_wait_entry: assert property (wait_exec && clk_en && cpu_clk_en |=>
        !cpu_clk_en && bus_clk_en && int_mask_clear) else $error("wait entry wrong");
    a_wait_exit: assert property (clk_en && !cpu_clk_en && bus_clk_en && irq_other |=>
        irq_resume && cpu_clk_en) else $error("wait exit wrong");
    a_asleep_status: assert property (clk_en && !cpu_clk_en && debug_clk_en && dbg_cmd_valid
        && dbg_cmd_mem_status && !dbg_cmd_background |=> dbg_status_error) else $error("no status error");
    a_illegal_stop: assert property (illegal_opcode_reset |->
        cpu_clk_en && bus_clk_en && $past(stop_exec)) else $error("illegal stop wrong");
    a_stop_clocks: assert property (!bus_clk_en |-> !cpu_clk_en && !periph_clk_en)
        else $error("clock left running");
    a_debug_regulator: assert property (!bus_clk_en && debug_clk_en |-> regulator_full)
        else $error("regulator in standby");
    a_stop3_reset: assert property (clk_en && state_retain && !reset_pin_n |=>
        chip_reset && bus_clk_en) else $error("stop3 reset exit wrong");
    a_stop2_hold: assert property (clk_en && core_powerdown && reset_pin_n && !irq_rtc |=>
        core_powerdown && pin_latch) else $error("stop2 left early");
    a_stop2_wake: assert property (s_stop2_wake |=> s_restart)
        else $error("stop2 wake wrong");
endmodule
bind low_power_mode_control lpm_props u_props (.*);

// file: tb/tb_low_power_mode_control.sv
`timescale 1ns/1ps
module tb_low_power_mode_control;
    logic pclk, presetn, psel, penable, pwrite, wait_exec, stop_exec, reset_pin_n, irq_other, e;
    logic debug_mode_enable, dbg_cmd_valid, dbg_cmd_background, dbg_cmd_mem_status, pready, pslverr;
    logic cpu_clk_en, bus_clk_en, periph_clk_en, debug_clk_en, regulator_full, int_ref_run, ext_ref_run;
    logic state_retain, core_powerdown, pin_latch, int_mask_clear, irq_resume, chip_reset, por_restart;
    logic illegal_opcode_reset, dbg_accept, dbg_status_error, active_bg_enter, clk_en, rtc_wake_enable;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [5:0] iq;
    int miscompares = 0, cmp_count = 0;
    low_power_mode_control DUT (.irq_rtc(iq[0]), .irq_lvd(iq[1]),
        .irq_analog_comparator(iq[2]), .irq_adc(iq[3]), .irq_sci(iq[4]), .irq_pin(iq[5]), .*);
    // ----
    // Bus and pulse helpers
    // ----
    task chk(input string n, input logic [31:0] x, g);
        cmp_count++;
        if (g !== x) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h got %h", n, x, g);
        end
    endtask
    task tally_and_finish;
        if (miscompares == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1);
        rd = prdata; er = pslverr; psel <= 0; penable <= 0;
    endtask
    task fire(input logic [3:0] k, input logic [6:0] q, input logic rp);
        @(posedge pclk);
        {wait_exec, stop_exec, dbg_cmd_background, dbg_cmd_mem_status} <= k;
        dbg_cmd_valid <= |k[1:0]; {irq_other, iq} <= q; reset_pin_n <= !rp;
        @(posedge pclk);
        {wait_exec, stop_exec, dbg_cmd_valid, irq_other, iq} <= 0; reset_pin_n <= 1;
        #1;
    endtask
    // x holds regulator, powerdown, then the por / irq / reset pulses expected at wake
    task stp(input logic d, input logic [8:0] c, input logic [6:0] q, input logic [4:0] x);
        debug_mode_enable <= d;
        apb(1, 8'h00, {23'h0, c}, r, e);
        fire(4'b0100, 0, 0);
        chk("stop outs", {x[4:3], 3'b0}, {regulator_full, core_powerdown, periph_clk_en, bus_clk_en, cpu_clk_en});
        chk("stop refs", {!x[3], !x[3] && c[4] && c[5], !x[3] && c[6] && c[7] && (!c[8] || c[1] && c[2])},
            {state_retain, int_ref_run, ext_ref_run});
        fire(0, q, q == 0);
        chk("wake", x[2:0], {por_restart, irq_resume, chip_reset});
        if (x[3]) begin
            apb(0, 8'h04, 0, r, e); chk("flag", 32'h60, r & 32'h60);
            apb(0, 8'h00, 0, r, e); chk("ctrl", 0, r);
            apb(1, 8'h08, 1, r, e);
            apb(0, 8'h04, 0, r, e); chk("latch", 0, {r[6:5], pin_latch});
        end
    endtask
    initial begin
        pclk = 0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        #200000;
        miscompares++;
        tally_and_finish;
    end
    initial begin
        {presetn, psel, penable, pwrite, wait_exec, stop_exec, irq_other, debug_mode_enable} = 0;
        {dbg_cmd_valid, dbg_cmd_background, dbg_cmd_mem_status, paddr, pwdata, iq} = 0;
        {reset_pin_n, clk_en, rtc_wake_enable} = 3'h7;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, 8'h00, 0, r, e); chk("ctrl rst", 0, r);
        apb(0, 8'h0C, 0, r, e); chk("unmapped", 1, e);
        clk_en <= 0; fire(4'b1000, 0, 0); chk("frozen", 1, cpu_clk_en); clk_en <= 1;
        fire(4'b0100, 0, 0); chk("illegal", 3, {illegal_opcode_reset, cpu_clk_en});
        fire(4'b1000, 0, 0); chk("wait in", 6, {bus_clk_en, int_mask_clear, cpu_clk_en});
        fire(4'b0001, 0, 0); chk("memstat", 3, {dbg_accept, dbg_status_error});
        fire(0, 7'h40, 0); chk("wait out", 3, {irq_resume, cpu_clk_en});
        fire(4'b1000, 0, 0);
        fire(4'b0010, 0, 0); chk("bgnd", 1, active_bg_enter);
        stp(1, 9'h009, 0, 5'b10001);
        fire(4'b0100, 0, 0); fire(4'b0010, 0, 0); chk("bg stop", 3, {active_bg_enter, cpu_clk_en});
        stp(0, 9'h1F7, 7'h02, 5'b10010);
        stp(0, 9'h1F1, 7'h08, 5'b00010);
        stp(0, 9'h009, 7'h01, 5'b01100);
        stp(0, 9'h009, 0, 5'b01100);
        rtc_wake_enable <= 0; apb(1, 8'h00, 32'h0000_0009, r, e);
        fire(4'b0100, 0, 0); fire(0, 7'h01, 0); chk("rtc off", 1, core_powerdown);
        fire(0, 0, 1); chk("pin wake", 1, por_restart);
        tally_and_finish;
    end
endmodule
